//--- bbt_translator.sv
// Base-and-bounds program-to-physical address translator with register port
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "bbt_defs.svh"

module bbt_translator
	import bbt_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_req_valid,
	input wire logic i_req_fetch,
	input wire logic i_req_kernel,
	input wire logic [63:0] i_req_addr,
	input wire logic [`BBT_ADDR_W-1:0] i_reg_addr,
	input wire logic [63:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic o_rsp_valid,
	output logic [31:0] o_rsp_paddr,
	output logic o_rsp_cached,
	output logic o_rsp_addr_err,
	output logic o_rsp_bound_err,
	output logic [31:0] o_reg_rdata,
	output logic o_irq
);

	logic [1:0] rst_sync_reg;
	logic rstn_int;
	bbt_req_t req;
	bbt_state_t state_reg;
	bbt_state_t state_next;

	// Segment of a 32-bit program address
	function automatic bbt_seg_t seg_of(input logic [31:0] addr);
		seg_of = bbt_seg_t'(addr[31:`BBT_SEG_LSB]);
	endfunction

	// Cacheability from the policy field picked by the segment
	function automatic logic policy_cached(input logic [23:0] policy, input bbt_seg_t seg);
		logic [2:0] code;
		code = policy[seg*`BBT_POLICY_FIELD_W +: `BBT_POLICY_FIELD_W];
		policy_cached = (code != `BBT_POLICY_UNCACHED);
	endfunction

	// Page above the limit
	function automatic logic beyond_limit(input logic [31:0] addr, input logic [31:0] limit);
		logic [19:0] page;
		logic [19:0] bound;
		page = addr[31:`BBT_PAGE_LSB];
		bound = {1'b0, limit[`BBT_LIMIT_MSB:`BBT_PAGE_LSB]};
		beyond_limit = (page > bound);
	endfunction

	// Relocate by base, offset passes unchanged
	function automatic logic [31:0] relocate(input logic [31:0] addr, input logic [31:0] base);
		logic [19:0] page;
		page = addr[31:`BBT_PAGE_LSB] + base[`BBT_BASE_MSB:`BBT_PAGE_LSB];
		relocate = {page, addr[`BBT_PAGE_LSB-1:0]};
	endfunction

	// Unmapped kernel window: top three bits cleared
	function automatic logic [31:0] unmapped(input logic [31:0] addr);
		unmapped = {3'h0, addr[`BBT_SEG_LSB-1:0]};
	endfunction

	// One-hot register select, zero when unmapped
	function automatic logic [7:0] reg_hit(input logic [`BBT_ADDR_W-1:0] addr);
		reg_hit = 8'h00;
		if (addr == `BBT_OFS_FETCH_BASE) begin
			reg_hit[`BBT_SEL_FETCH_BASE] = 1'b1;
		end else if (addr == `BBT_OFS_FETCH_LIMIT) begin
			reg_hit[`BBT_SEL_FETCH_LIMIT] = 1'b1;
		end else if (addr == `BBT_OFS_LS_BASE) begin
			reg_hit[`BBT_SEL_LS_BASE] = 1'b1;
		end else if (addr == `BBT_OFS_LS_LIMIT) begin
			reg_hit[`BBT_SEL_LS_LIMIT] = 1'b1;
		end else if (addr == `BBT_OFS_CACHE_POLICY) begin
			reg_hit[`BBT_SEL_CACHE_POLICY] = 1'b1;
		end else if (addr == `BBT_OFS_IRQ_STATUS) begin
			reg_hit[`BBT_SEL_IRQ_STATUS] = 1'b1;
		end else if (addr == `BBT_OFS_IRQ_MASK) begin
			reg_hit[`BBT_SEL_IRQ_MASK] = 1'b1;
		end else if (addr == `BBT_OFS_FAULT_ADDR) begin
			reg_hit[`BBT_SEL_FAULT_ADDR] = 1'b1;
		end
	endfunction

	// Plain register writes; status clears and fault address kept apart
	function automatic bbt_state_t write_regs(input bbt_state_t st, input logic [7:0] hit,
		input logic [31:0] wdata);
		write_regs = st;
		if (hit[`BBT_SEL_FETCH_BASE]) begin
			write_regs.fetch_base = wdata;
		end
		if (hit[`BBT_SEL_FETCH_LIMIT]) begin
			write_regs.fetch_limit = wdata;
		end
		if (hit[`BBT_SEL_LS_BASE]) begin
			write_regs.ls_base = wdata;
		end
		if (hit[`BBT_SEL_LS_LIMIT]) begin
			write_regs.ls_limit = wdata;
		end
		if (hit[`BBT_SEL_CACHE_POLICY]) begin
			write_regs.cache_policy = wdata[`BBT_POLICY_W-1:0];
		end
		if (hit[`BBT_SEL_IRQ_MASK]) begin
			write_regs.irq_mask = wdata[`BBT_IRQ_W-1:0];
		end
	endfunction

	// Read word of the selected register, unused bits zero
	function automatic logic [31:0] read_word(input bbt_state_t st, input logic [7:0] hit);
		read_word = 32'h0;
		if (hit[`BBT_SEL_FETCH_BASE]) begin
			read_word = st.fetch_base;
		end else if (hit[`BBT_SEL_FETCH_LIMIT]) begin
			read_word = st.fetch_limit;
		end else if (hit[`BBT_SEL_LS_BASE]) begin
			read_word = st.ls_base;
		end else if (hit[`BBT_SEL_LS_LIMIT]) begin
			read_word = st.ls_limit;
		end else if (hit[`BBT_SEL_CACHE_POLICY]) begin
			read_word = {8'h00, st.cache_policy};
		end else if (hit[`BBT_SEL_IRQ_STATUS]) begin
			read_word = {30'h0, st.irq_status};
		end else if (hit[`BBT_SEL_IRQ_MASK]) begin
			read_word = {30'h0, st.irq_mask};
		end else if (hit[`BBT_SEL_FAULT_ADDR]) begin
			read_word = st.fault_addr;
		end
	endfunction

	// Sticky status: a new event wins over a clear in the same cycle
	function automatic logic [1:0] status_update(input logic [1:0] status,
		input logic [1:0] clr, input logic [1:0] events);
		status_update = (status & ~clr) | events;
	endfunction

	// One request: segment, privilege, limit check and relocation
	function automatic bbt_rsp_t translate(input bbt_req_t rq, input bbt_state_t st);
		logic [31:0] vaddr;
		logic [31:0] base;
		logic [31:0] limit;
		bbt_seg_t seg;
		bbt_rsp_t rsp;
		vaddr = rq.addr[31:0];
		seg = seg_of(vaddr);
		rsp = '0;
		rsp.valid = rq.valid;
		if (rq.fetch) begin
			base = st.fetch_base;
			limit = st.fetch_limit;
		end else begin
			base = st.ls_base;
			limit = st.ls_limit;
		end
		if (rq.valid && vaddr[31] && !rq.kernel) begin
			rsp.addr_err = 1'b1;
		end else if (rq.valid) begin
			case (seg)
				BBT_SEG_USER0, BBT_SEG_USER1, BBT_SEG_USER2, BBT_SEG_USER3: begin
					// Same relocation from both levels
					if (beyond_limit(vaddr, limit)) begin
						rsp.bound_err = 1'b1;
					end else begin
						rsp.paddr = relocate(vaddr, base);
						rsp.cached = policy_cached(st.cache_policy, seg);
					end
				end
				BBT_SEG_KCACHED: begin
					rsp.paddr = unmapped(vaddr);
					rsp.cached = policy_cached(st.cache_policy, seg);
				end
				BBT_SEG_KUNCACHED: begin
					rsp.paddr = unmapped(vaddr);
					rsp.cached = policy_cached(st.cache_policy, seg);
				end
				default: begin
					// Kernel high window, both halves
					rsp.paddr = unmapped(vaddr);
					rsp.cached = policy_cached(st.cache_policy, seg);
				end
			endcase
		end
		translate = rsp;
	endfunction

	// Reset released through two flip-flops
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rstn_int = rst_sync_reg[1];

	assign req.valid = i_req_valid;
	assign req.fetch = i_req_fetch;
	assign req.kernel = i_req_kernel;
	assign req.addr = i_req_addr;

	always_comb begin
		logic [31:0] wdata;
		logic [7:0] wr_hit;
		logic [7:0] rd_hit;
		logic [1:0] events;
		logic [1:0] clr;
		wdata = i_reg_wdata[31:0];
		wr_hit = 8'h00;
		rd_hit = 8'h00;
		events = 2'h0;
		clr = 2'h0;
		if (i_reg_wr) begin
			wr_hit = reg_hit(i_reg_addr);
		end
		if (i_reg_rd) begin
			rd_hit = reg_hit(i_reg_addr);
		end

		// Requests see the registers as they stood before this edge
		state_next = write_regs(state_reg, wr_hit, wdata);
		state_next.rsp = translate(req, state_reg);
		events[`BBT_IRQ_ADDR_ERR] = state_next.rsp.addr_err;
		events[`BBT_IRQ_BOUND_ERR] = state_next.rsp.bound_err;
		if (|events) begin
			state_next.fault_addr = req.addr[31:0];
		end

		// Sticky status, write one to clear
		if (wr_hit[`BBT_SEL_IRQ_STATUS]) begin
			clr = wdata[`BBT_IRQ_W-1:0];
		end
		state_next.irq_status = status_update(state_reg.irq_status, clr, events);
		state_next.irq = |(state_next.irq_status & state_next.irq_mask);

		// Read data stands in the following cycle only
		state_next.rdata = read_word(state_reg, rd_hit);
	end

	always_ff @(posedge i_ref_clk or negedge rstn_int) begin
		if (!rstn_int) begin
			state_reg <= '0;
			state_reg.cache_policy <= `BBT_POLICY_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_rsp_valid = state_reg.rsp.valid;
	assign o_rsp_paddr = state_reg.rsp.paddr;
	assign o_rsp_cached = state_reg.rsp.cached;
	assign o_rsp_addr_err = state_reg.rsp.addr_err;
	assign o_rsp_bound_err = state_reg.rsp.bound_err;
	assign o_reg_rdata = state_reg.rdata;
	assign o_irq = state_reg.irq;

endmodule

//--- bbt_defs.svh
// Offsets, field layouts, reset values and codes of the address translator
`ifndef BBT_DEFS_SVH
`define BBT_DEFS_SVH

`define BBT_ADDR_W 8
`define BBT_OFS_FETCH_BASE 8'h00
`define BBT_OFS_FETCH_LIMIT 8'h04
`define BBT_OFS_LS_BASE 8'h08
`define BBT_OFS_LS_LIMIT 8'h0C
`define BBT_OFS_CACHE_POLICY 8'h10
`define BBT_OFS_IRQ_STATUS 8'h14
`define BBT_OFS_IRQ_MASK 8'h18
`define BBT_OFS_FAULT_ADDR 8'h1C

`define BBT_SEL_FETCH_BASE 0
`define BBT_SEL_FETCH_LIMIT 1
`define BBT_SEL_LS_BASE 2
`define BBT_SEL_LS_LIMIT 3
`define BBT_SEL_CACHE_POLICY 4
`define BBT_SEL_IRQ_STATUS 5
`define BBT_SEL_IRQ_MASK 6
`define BBT_SEL_FAULT_ADDR 7

`define BBT_PAGE_LSB 12
`define BBT_BASE_MSB 31
`define BBT_LIMIT_MSB 30
`define BBT_SEG_LSB 29

`define BBT_POLICY_FIELD_W 3
`define BBT_POLICY_W 24
`define BBT_POLICY_UNCACHED 3'h2
`define BBT_POLICY_RESET 24'h6D36DB

`define BBT_IRQ_W 2
`define BBT_IRQ_ADDR_ERR 0
`define BBT_IRQ_BOUND_ERR 1

`endif

//--- bbt_pkg.sv
// Types shared by the address translator
package bbt_pkg;

	typedef enum logic [2:0] {
		BBT_SEG_USER0 = 3'b000,
		BBT_SEG_USER1 = 3'b001,
		BBT_SEG_USER2 = 3'b010,
		BBT_SEG_USER3 = 3'b011,
		BBT_SEG_KCACHED = 3'b100,
		BBT_SEG_KUNCACHED = 3'b101,
		BBT_SEG_KHIGH0 = 3'b110,
		BBT_SEG_KHIGH1 = 3'b111
	} bbt_seg_t;

	typedef struct packed {
		logic valid;
		logic fetch;
		logic kernel;
		logic [63:0] addr;
	} bbt_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] paddr;
		logic cached;
		logic addr_err;
		logic bound_err;
	} bbt_rsp_t;

	typedef struct packed {
		logic [31:0] fetch_base;
		logic [31:0] fetch_limit;
		logic [31:0] ls_base;
		logic [31:0] ls_limit;
		logic [23:0] cache_policy;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic [31:0] fault_addr;
		logic [31:0] rdata;
		bbt_rsp_t rsp;
		logic irq;
	} bbt_state_t;

endpackage

//--- bbt_chk.sv
// Port checker of the address translator
`timescale 1ns/1ps
module bbt_chk(
	input logic i_ref_clk,
	input logic i_rstn,
	input logic i_req_valid,
	input logic i_req_kernel,
	input logic [63:0] i_req_addr,
	input logic o_rsp_valid,
	input logic o_rsp_cached,
	input logic o_rsp_addr_err,
	input logic o_rsp_bound_err,
	input logic [31:0] o_rsp_paddr
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	valid_follow_a: assert property (o_rsp_valid == $past(i_req_valid))
		else $error("response valid mismatch");
	user_high_a: assert property (i_req_valid && !i_req_kernel && i_req_addr[31] |=>
		o_rsp_addr_err && !o_rsp_bound_err) else $error("user high address not refused");
	kern_no_err_a: assert property (i_req_valid && i_req_kernel |=> !o_rsp_addr_err)
		else $error("kernel address error");
	kwin_map_a: assert property (i_req_valid && i_req_kernel && i_req_addr[31] |=>
		o_rsp_paddr == {3'h0, $past(i_req_addr[28:0])} && !o_rsp_bound_err)
		else $error("kernel window address wrong");
	err_zero_a: assert property (o_rsp_addr_err || o_rsp_bound_err |->
		o_rsp_valid && !o_rsp_cached && o_rsp_paddr == 32'h0) else $error("error result");
	idle_zero_a: assert property (!o_rsp_valid |-> !o_rsp_addr_err && !o_rsp_bound_err &&
		o_rsp_paddr == 32'h0) else $error("idle result not zero");
	page_zero_a: assert property (i_req_valid && i_req_addr[31:12] == 20'h0 |=>
		!o_rsp_bound_err && o_rsp_paddr[11:0] == $past(i_req_addr[11:0]))
		else $error("page zero result wrong");
	bound_seg_a: assert property (o_rsp_bound_err |-> !$past(i_req_addr[31]))
		else $error("bound error outside user segment");
	cover property (o_rsp_addr_err);
	cover property (o_rsp_bound_err);
	cover property (o_rsp_valid && o_rsp_cached);
endmodule

bind bbt_translator bbt_chk u_chk (
	.i_ref_clk(i_ref_clk),
	.i_rstn(i_rstn),
	.i_req_valid(i_req_valid),
	.i_req_kernel(i_req_kernel),
	.i_req_addr(i_req_addr),
	.o_rsp_valid(o_rsp_valid),
	.o_rsp_cached(o_rsp_cached),
	.o_rsp_addr_err(o_rsp_addr_err),
	.o_rsp_bound_err(o_rsp_bound_err),
	.o_rsp_paddr(o_rsp_paddr)
);

//--- bbt_core.sv
// Core pipeline model issuing translation requests
`timescale 1ns/1ps
module bbt_core(
	input wire logic i_ref_clk,
	output logic o_valid,
	output logic o_fetch,
	output logic o_kernel,
	output logic [63:0] o_addr
);
	initial {o_valid, o_fetch, o_kernel, o_addr} = '0;
	task automatic issue(input logic f, k, input logic [63:0] a);
		@(posedge i_ref_clk);
		{o_valid, o_fetch, o_kernel, o_addr} <= {1'b1, f, k, a};
		@(posedge i_ref_clk);
		o_valid <= 1'b0;
		o_addr <= ~a; // Stale address never repeats
	endtask
endmodule

//--- testbench.sv
// Self-checking bench of the address translator
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rstn = 0, wr = 0, rd = 0;
	logic [7:0] ra = 8'h0;
	logic [63:0] wd = 64'h0;
	logic v, f, k, rv, pc, ae, be, irq;
	logic [63:0] a;
	logic [31:0] pa, rdat;
	int num_errors = 0, total_checks = 0, cyc = 0;
	always #2.5 clk = ~clk;
	bbt_core u_core(.i_ref_clk(clk), .o_valid(v), .o_fetch(f), .o_kernel(k), .o_addr(a));
	bbt_translator u_dut(.i_ref_clk(clk), .i_rstn(rstn), .i_req_valid(v), .i_req_fetch(f),
		.i_req_kernel(k), .i_req_addr(a), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
		.i_reg_rd(rd), .o_rsp_valid(rv), .o_rsp_paddr(pa), .o_rsp_cached(pc),
		.o_rsp_addr_err(ae), .o_rsp_bound_err(be), .o_reg_rdata(rdat), .o_irq(irq));
	task automatic chk(input string n, input logic [35:0] s, e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		{wr, ra, wd} <= {1'b1, ad, 32'hFFFFFFFF, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] ad, input logic [31:0] e, input string n);
		@(posedge clk);
		{rd, ra} <= {1'b1, ad};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, rdat, e);
	endtask
	task automatic tr(input logic ff, kk, input logic [63:0] ad, input logic [34:0] e);
		u_core.issue(ff, kk, ad);
		#1 chk("response", {rv, pa, pc, ae, be}, {1'b1, e});
	endtask
	task automatic scn_reset;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("irq", irq, 1'b0);
		rreg(8'h10, 32'h006D36DB, "policy");
		rreg(8'h18, 32'h0, "mask");
		rreg(8'h14, 32'h0, "status");
		rreg(8'h1C, 32'h0, "fault");
		tr(0, 1, 64'hE0000020, {32'h00000020, 3'b100});
	endtask
	task automatic scn_regs;
		wreg(8'h00, 32'h10000000);
		wreg(8'h04, 32'h00005000);
		wreg(8'h08, 32'h20000000);
		wreg(8'h0C, 32'h00001000);
		wreg(8'h18, 32'h3);
		wreg(8'h1C, 32'h12345678);
		rreg(8'h00, 32'h10000000, "fetch base");
		rreg(8'h04, 32'h00005000, "fetch limit");
		rreg(8'h08, 32'h20000000, "ls base");
		rreg(8'h0C, 32'h00001000, "ls limit");
		rreg(8'h18, 32'h3, "mask");
		rreg(8'h1C, 32'h0, "fault read-only");
		rreg(8'h20, 32'h0, "unmapped");
	endtask
	task automatic scn_user;
		tr(1, 0, 64'hDEADBEEF_00003ABC, {32'h10003ABC, 3'b100});
		tr(1, 0, 64'h00005FFF, {32'h10005FFF, 3'b100});
		tr(1, 0, 64'h00006000, {32'h0, 3'b001});
		tr(0, 0, 64'h00001FFF, {32'h20001FFF, 3'b100});
		tr(0, 0, 64'h00002000, {32'h0, 3'b001});
		tr(1, 1, 64'h00000ABC, {32'h10000ABC, 3'b100});
	endtask
	task automatic scn_errors;
		wreg(8'h14, 32'h3);
		tr(1, 0, 64'h80000000, {32'h0, 3'b010});
		#1 chk("irq", irq, 1'b1);
		rreg(8'h14, 32'h1, "status");
		rreg(8'h1C, 32'h80000000, "fault");
		tr(0, 1, 64'h00003ABC, {32'h0, 3'b001});
		rreg(8'h14, 32'h3, "status");
		rreg(8'h1C, 32'h00003ABC, "fault");
		wreg(8'h14, 32'h3);
		#1 chk("irq", irq, 1'b0);
	endtask
	task automatic scn_kernel;
		tr(0, 1, 64'h80000010, {32'h00000010, 3'b100});
		tr(0, 1, 64'hA0001234, {32'h00001234, 3'b000});
		tr(0, 1, 64'hE0000020, {32'h00000020, 3'b100});
		wreg(8'h10, 32'h004DB6DB);
		tr(0, 1, 64'hE0000020, {32'h00000020, 3'b000});
		tr(0, 1, 64'hC0000008, {32'h00000008, 3'b100});
		tr(0, 1, 64'hA0001234, {32'h00001234, 3'b100});
		tr(1, 1, 64'h80000010, {32'h00000010, 3'b100});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	initial begin
		scn_reset;
		scn_regs;
		scn_user;
		scn_errors;
		scn_kernel;
		// Reset in mid-run restores the policy and clears all state
		scn_reset;
		tally_and_finish;
	end
endmodule
